// file: src/usbsr_consts.vh
// constants and register map of the standard request state block
// Contract
// - cpu writes to the two bulk endpoint status registers take effect only while nak-all is 1.
// - a cpu write to an endpoint status register is dropped while that endpoint is busy on usb.
// - an error on endpoint 1 or endpoint 2 sets that endpoint's halt bit.
// - the halt bit sits at bit 0 of each bulk status register, 1 meaning stalled, rest zero.
// - get_status to endpoint 1 or 2 is answered by hardware with that status register.
// - a stall of endpoint 1 empties the bulk-in fifo and clears bulk-in nak release.
// - a stall of endpoint 2 empties the bulk-out fifo and clears bulk-out nak release.
// - set_address is decoded and its 7-bit address stored in a read-only field, bits 6..0.
// - the stored address is put to use only after the status stage reports success.
// - set_configuration stores its value in a read-only 2-bit field returned on get_configuration.
// - a configuration change from zero to nonzero sets the configured bit of mode status.
// - the configuration shows in mode status at once, before the status stage ends.
// - bulk-in data answers an in token only while bulk-in nak release is 1, else nak.
`ifndef USBSR_CONSTS_VH
`define USBSR_CONSTS_VH

// ==========================================
// register indices, byte address is index times four
`define USBSR_IDX_ADDR 16'hFF90
`define USBSR_IDX_CNF 16'hFF91
`define USBSR_IDX_EP1 16'hFF9D
`define USBSR_IDX_EP2 16'hFF9E
`define USBSR_IDX_CTRL 16'hFFA0
`define USBSR_IDX_MODE 16'hFFA1
`define USBSR_IDX_IRQ 16'hFFA2
`define USBSR_IDX_MASK 16'hFFA3

// ==========================================
// field positions
`define USBSR_HALT_BIT 0
`define USBSR_ADDR_W 7
`define USBSR_CNF_W 2
`define USBSR_CTRL_NAK_ALL 0
`define USBSR_CTRL_IN_REL 1
`define USBSR_CTRL_OUT_REL 2
`define USBSR_CTRL_W 3
`define USBSR_MODE_CONF 0
`define USBSR_IRQ_EP1_STALL 0
`define USBSR_IRQ_EP2_STALL 1
`define USBSR_IRQ_CONF 2
`define USBSR_IRQ_ADDR 3
`define USBSR_IRQ_W 4

// ==========================================
// reset values
`define USBSR_RST_BYTE 8'h00
`define USBSR_RST_CTRL 3'h0
`define USBSR_RST_IRQ 4'h0

// ==========================================
// standard request codes and recipients
`define USBSR_REQ_GET_STATUS 8'h00
`define USBSR_REQ_CLR_FEATURE 8'h01
`define USBSR_REQ_SET_FEATURE 8'h03
`define USBSR_REQ_SET_ADDRESS 8'h05
`define USBSR_REQ_GET_CONFIG 8'h08
`define USBSR_REQ_SET_CONFIG 8'h09
`define USBSR_REQ_SET_INTF 8'h0B
`define USBSR_RCP_DEVICE 5'h00
`define USBSR_RCP_INTF 5'h01
`define USBSR_RCP_EP 5'h02
`define USBSR_EP_BULK_IN 4'h1
`define USBSR_EP_BULK_OUT 4'h2

// ==========================================
// axi responses
`define USBSR_RESP_OKAY 2'h0
`define USBSR_RESP_SLVERR 2'h2

`endif

// file: src/usbsr_req_decode.v
// setup packet decoder for standard requests
`timescale 1ns/1ps
`default_nettype none
`include "usbsr_consts.vh"
module usbsr_req_decode #(
    parameter [7:0] BULK_INTF = 8'h00
) (
    input wire setup_valid,
    input wire [7:0] setup_rtype,
    input wire [7:0] setup_req,
    input wire [15:0] setup_index,
    output wire set_addr,
    output wire set_cfg,
    output wire get_cfg,
    output wire get_st_ep1,
    output wire get_st_ep2,
    output wire set_ft_ep1,
    output wire set_ft_ep2,
    output wire clr_ft_ep1,
    output wire clr_ft_ep2,
    output wire set_intf
);
    // ==========================================
    // recipient and endpoint match
    wire std_req;
    wire to_dev;
    wire to_ep;
    wire ep1;
    wire ep2;
    assign std_req = setup_valid && (setup_rtype[6:5] == 2'h0);
    assign to_dev = std_req && (setup_rtype[4:0] == `USBSR_RCP_DEVICE);
    assign to_ep = std_req && (setup_rtype[4:0] == `USBSR_RCP_EP);
    assign ep1 = to_ep && (setup_index[3:0] == `USBSR_EP_BULK_IN);
    assign ep2 = to_ep && (setup_index[3:0] == `USBSR_EP_BULK_OUT);

    // ==========================================
    // request strobes
    assign set_addr = to_dev && (setup_req == `USBSR_REQ_SET_ADDRESS);
    assign set_cfg = to_dev && (setup_req == `USBSR_REQ_SET_CONFIG);
    assign get_cfg = to_dev && (setup_req == `USBSR_REQ_GET_CONFIG);
    assign get_st_ep1 = ep1 && (setup_req == `USBSR_REQ_GET_STATUS);
    assign get_st_ep2 = ep2 && (setup_req == `USBSR_REQ_GET_STATUS);
    assign set_ft_ep1 = ep1 && (setup_req == `USBSR_REQ_SET_FEATURE);
    assign set_ft_ep2 = ep2 && (setup_req == `USBSR_REQ_SET_FEATURE);
    assign clr_ft_ep1 = ep1 && (setup_req == `USBSR_REQ_CLR_FEATURE);
    assign clr_ft_ep2 = ep2 && (setup_req == `USBSR_REQ_CLR_FEATURE);
    // only the interface owning both bulk endpoints resets them
    assign set_intf = std_req && (setup_rtype[4:0] == `USBSR_RCP_INTF)
        && (setup_req == `USBSR_REQ_SET_INTF) && (setup_index[7:0] == BULK_INTF);
endmodule
`default_nettype wire

// file: src/usbsr_top.v
// standard request state registers with axi4-lite slave
`timescale 1ns/1ps
`default_nettype none
`include "usbsr_consts.vh"
module usbsr_top #(
    parameter AW = 18,
    parameter [7:0] BULK_INTF = 8'h00
) (
    input wire ref_clk,
    input wire rstn,
    input wire [AW-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [AW-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire setup_valid,
    input wire [7:0] setup_rtype,
    input wire [7:0] setup_req,
    input wire [15:0] setup_value,
    input wire [15:0] setup_index,
    input wire status_ok,
    input wire ep1_busy,
    input wire ep2_busy,
    input wire ep1_error,
    input wire ep2_error,
    input wire in_token,
    output reg ans_valid,
    output reg [7:0] ans_data,
    output reg [6:0] dev_addr,
    output reg bulk_in_send,
    output reg bulk_in_nak,
    output reg bulk_out_accept,
    output reg bulk_in_fifo_clr,
    output reg bulk_out_fifo_clr,
    output reg ep1_toggle_clr,
    output reg ep2_toggle_clr,
    output reg irq
);
    // ==========================================
    // reset synchroniser
    reg rst_s1_ff;
    reg rst_n_ff;
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rst_s1_ff <= 1'b0;
            rst_n_ff <= 1'b0;
        end else begin
            rst_s1_ff <= 1'b1;
            rst_n_ff <= rst_s1_ff;
        end
    end

    // ==========================================
    // request decode
    wire set_addr;
    wire set_cfg;
    wire get_cfg;
    wire get_st_ep1;
    wire get_st_ep2;
    wire set_ft_ep1;
    wire set_ft_ep2;
    wire clr_ft_ep1;
    wire clr_ft_ep2;
    wire set_intf;
    usbsr_req_decode #(.BULK_INTF(BULK_INTF)) u_dec (
        .setup_valid(setup_valid),
        .setup_rtype(setup_rtype),
        .setup_req(setup_req),
        .setup_index(setup_index),
        .set_addr(set_addr),
        .set_cfg(set_cfg),
        .get_cfg(get_cfg),
        .get_st_ep1(get_st_ep1),
        .get_st_ep2(get_st_ep2),
        .set_ft_ep1(set_ft_ep1),
        .set_ft_ep2(set_ft_ep2),
        .clr_ft_ep1(clr_ft_ep1),
        .clr_ft_ep2(clr_ft_ep2),
        .set_intf(set_intf)
    );

    // ==========================================
    // axi write channel
    reg aw_got_ff;
    reg w_got_ff;
    reg [15:0] aw_idx_ff;
    reg [7:0] wbyte_ff;
    reg wlane_ff;
    wire wr_go;
    assign s_axi_awready = !aw_got_ff && !s_axi_bvalid;
    assign s_axi_wready = !w_got_ff && !s_axi_bvalid;
    assign wr_go = aw_got_ff && w_got_ff && !s_axi_bvalid;
    wire wr_known;
    assign wr_known = (aw_idx_ff == `USBSR_IDX_ADDR) || (aw_idx_ff == `USBSR_IDX_CNF)
        || (aw_idx_ff == `USBSR_IDX_EP1) || (aw_idx_ff == `USBSR_IDX_EP2)
        || (aw_idx_ff == `USBSR_IDX_CTRL) || (aw_idx_ff == `USBSR_IDX_MODE)
        || (aw_idx_ff == `USBSR_IDX_IRQ) || (aw_idx_ff == `USBSR_IDX_MASK);
    wire wr_en;
    assign wr_en = wr_go && wlane_ff;
    always @(posedge ref_clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            aw_idx_ff <= 16'h0000;
            wbyte_ff <= `USBSR_RST_BYTE;
            wlane_ff <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `USBSR_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_ff <= 1'b1;
                aw_idx_ff <= s_axi_awaddr[17:2];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_ff <= 1'b1;
                wbyte_ff <= s_axi_wdata[7:0];
                wlane_ff <= s_axi_wstrb[0];
            end
            if (wr_go) begin
                aw_got_ff <= 1'b0;
                w_got_ff <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_known ? `USBSR_RESP_OKAY : `USBSR_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ==========================================
    // state registers
    reg ep1_halt_ff;
    reg ep2_halt_ff;
    reg [6:0] addr_ff;
    reg addr_pend_ff;
    reg [1:0] cnf_ff;
    reg conf_ff;
    reg [2:0] ctrl_ff;
    reg [3:0] irq_st_ff;
    reg [3:0] irq_mask_ff;
    wire nak_all;
    wire ep_wr_ok;
    wire ep1_wr;
    wire ep2_wr;
    assign nak_all = ctrl_ff[`USBSR_CTRL_NAK_ALL];
    assign ep_wr_ok = wr_en && nak_all;
    assign ep1_wr = ep_wr_ok && !ep1_busy && (aw_idx_ff == `USBSR_IDX_EP1);
    assign ep2_wr = ep_wr_ok && !ep2_busy && (aw_idx_ff == `USBSR_IDX_EP2);
    wire ep_clr_all;
    assign ep_clr_all = set_cfg || set_intf;

    reg nxt_ep1_halt;
    reg nxt_ep2_halt;
    always @* begin
        nxt_ep1_halt = ep1_halt_ff;
        if (ep1_wr) begin
            nxt_ep1_halt = wbyte_ff[`USBSR_HALT_BIT];
        end
        if (clr_ft_ep1 || ep_clr_all) begin
            nxt_ep1_halt = 1'b0;
        end
        if (set_ft_ep1 || ep1_error) begin
            nxt_ep1_halt = 1'b1;
        end
        nxt_ep2_halt = ep2_halt_ff;
        if (ep2_wr) begin
            nxt_ep2_halt = wbyte_ff[`USBSR_HALT_BIT];
        end
        if (clr_ft_ep2 || ep_clr_all) begin
            nxt_ep2_halt = 1'b0;
        end
        if (set_ft_ep2 || ep2_error) begin
            nxt_ep2_halt = 1'b1;
        end
    end

    // a stall is the halt bit rising, whatever caused it
    wire ep1_stall;
    wire ep2_stall;
    assign ep1_stall = nxt_ep1_halt && !ep1_halt_ff;
    assign ep2_stall = nxt_ep2_halt && !ep2_halt_ff;
    wire conf_rise;
    assign conf_rise = set_cfg && (cnf_ff == 2'h0) && (setup_value[1:0] != 2'h0);

    reg [2:0] nxt_ctrl;
    always @* begin
        nxt_ctrl = ctrl_ff;
        if (wr_en && (aw_idx_ff == `USBSR_IDX_CTRL)) begin
            nxt_ctrl = wbyte_ff[2:0];
        end
        // hardware clear beats a firmware write in the same cycle
        if (ep1_stall) begin
            nxt_ctrl[`USBSR_CTRL_IN_REL] = 1'b0;
        end
        if (ep2_stall) begin
            nxt_ctrl[`USBSR_CTRL_OUT_REL] = 1'b0;
        end
    end

    wire [3:0] irq_ev;
    assign irq_ev = {addr_pend_ff && status_ok, conf_rise, ep2_stall, ep1_stall};
    wire [3:0] irq_w1c;
    assign irq_w1c = (wr_en && (aw_idx_ff == `USBSR_IDX_IRQ)) ? wbyte_ff[3:0] : 4'h0;

    always @(posedge ref_clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            ep1_halt_ff <= 1'b0;
            ep2_halt_ff <= 1'b0;
            addr_ff <= 7'h00;
            addr_pend_ff <= 1'b0;
            dev_addr <= 7'h00;
            cnf_ff <= 2'h0;
            conf_ff <= 1'b0;
            ctrl_ff <= `USBSR_RST_CTRL;
            irq_st_ff <= `USBSR_RST_IRQ;
            irq_mask_ff <= `USBSR_RST_IRQ;
            irq <= 1'b0;
            bulk_in_fifo_clr <= 1'b0;
            bulk_out_fifo_clr <= 1'b0;
            ep1_toggle_clr <= 1'b0;
            ep2_toggle_clr <= 1'b0;
        end else begin
            ep1_halt_ff <= nxt_ep1_halt;
            ep2_halt_ff <= nxt_ep2_halt;
            ctrl_ff <= nxt_ctrl;
            bulk_in_fifo_clr <= ep1_stall;
            bulk_out_fifo_clr <= ep2_stall;
            ep1_toggle_clr <= clr_ft_ep1 || ep_clr_all;
            ep2_toggle_clr <= clr_ft_ep2 || ep_clr_all;
            if (set_addr) begin
                addr_ff <= setup_value[6:0];
                addr_pend_ff <= 1'b1;
            end else if (addr_pend_ff && status_ok) begin
                dev_addr <= addr_ff;
                addr_pend_ff <= 1'b0;
            end
            if (set_cfg) begin
                cnf_ff <= setup_value[1:0];
                // shows now, not after the status stage
                conf_ff <= (setup_value[1:0] != 2'h0);
            end
            if (wr_en && (aw_idx_ff == `USBSR_IDX_MASK)) begin
                irq_mask_ff <= wbyte_ff[3:0];
            end
            irq_st_ff <= (irq_st_ff & ~irq_w1c) | irq_ev;
            irq <= |(((irq_st_ff & ~irq_w1c) | irq_ev) & irq_mask_ff);
        end
    end

    // ==========================================
    // usb side answers
    always @(posedge ref_clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            ans_valid <= 1'b0;
            ans_data <= `USBSR_RST_BYTE;
            bulk_in_send <= 1'b0;
            bulk_in_nak <= 1'b0;
            bulk_out_accept <= 1'b0;
        end else begin
            ans_valid <= get_st_ep1 || get_st_ep2 || get_cfg;
            if (get_st_ep1) begin
                ans_data <= {7'h00, ep1_halt_ff};
            end else if (get_st_ep2) begin
                ans_data <= {7'h00, ep2_halt_ff};
            end else if (get_cfg) begin
                ans_data <= {6'h00, cnf_ff};
            end
            bulk_in_send <= in_token && ctrl_ff[`USBSR_CTRL_IN_REL];
            bulk_in_nak <= in_token && !ctrl_ff[`USBSR_CTRL_IN_REL];
            bulk_out_accept <= ctrl_ff[`USBSR_CTRL_OUT_REL];
        end
    end

    // ==========================================
    // axi read channel
    reg [7:0] rd_byte;
    reg rd_known;
    assign s_axi_arready = !s_axi_rvalid;
    always @* begin
        rd_byte = 8'h00;
        rd_known = 1'b1;
        case (s_axi_araddr[17:2])
            `USBSR_IDX_ADDR: rd_byte = {1'b0, addr_ff};
            `USBSR_IDX_CNF: rd_byte = {6'h00, cnf_ff};
            `USBSR_IDX_EP1: rd_byte = {7'h00, ep1_halt_ff};
            `USBSR_IDX_EP2: rd_byte = {7'h00, ep2_halt_ff};
            `USBSR_IDX_CTRL: rd_byte = {5'h00, ctrl_ff};
            `USBSR_IDX_MODE: rd_byte = {7'h00, conf_ff};
            `USBSR_IDX_IRQ: rd_byte = {4'h0, irq_st_ff};
            `USBSR_IDX_MASK: rd_byte = {4'h0, irq_mask_ff};
            default: rd_known = 1'b0;
        endcase
    end
    always @(posedge ref_clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `USBSR_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, rd_byte};
            s_axi_rresp <= rd_known ? `USBSR_RESP_OKAY : `USBSR_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// file: tb/usbsr_host_model.sv
// usb host model issuing standard control requests
`timescale 1ns/1ps
`default_nettype none
module usbsr_host_model (
    input wire logic ref_clk,
    output logic setup_valid,
    output logic [7:0] setup_rtype,
    output logic [7:0] setup_req,
    output logic [15:0] setup_value,
    output logic [15:0] setup_index,
    output logic status_ok
);
    // ==========================================
    // setup and status stages
    initial begin
        setup_valid = 1'h0;
        setup_rtype = 8'h00;
        setup_req = 8'h00;
        setup_value = 16'h0000;
        setup_index = 16'h0000;
        status_ok = 1'h0;
    end
    task automatic req(input logic [7:0] rt, input logic [7:0] rq, input logic [15:0] v,
        input logic [15:0] ix);
        @(posedge ref_clk);
        setup_valid <= 1'h1;
        setup_rtype <= rt;
        setup_req <= rq;
        setup_value <= v;
        setup_index <= ix;
        @(posedge ref_clk);
        // fields are stale once valid drops, so scramble them
        setup_valid <= 1'h0;
        setup_rtype <= ~rt;
        setup_req <= ~rq;
        setup_value <= ~v;
        setup_index <= ~ix;
    endtask
    // gap lets the status stage come late
    task automatic ok(input int gap);
        repeat (gap) @(posedge ref_clk);
        @(posedge ref_clk);
        status_ok <= 1'h1;
        @(posedge ref_clk);
        status_ok <= 1'h0;
    endtask
endmodule
`default_nettype wire

// file: tb/usbsr_sva.sv
// port checker of the standard request state block
`timescale 1ns/1ps
`default_nettype none
`include "usbsr_consts.vh"
module usbsr_sva (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic setup_valid,
    input wire logic [7:0] setup_rtype,
    input wire logic [7:0] setup_req,
    input wire logic [15:0] setup_index,
    input wire logic status_ok,
    input wire logic ep1_error,
    input wire logic ep2_error,
    input wire logic in_token,
    input wire logic ans_valid,
    input wire logic [6:0] dev_addr,
    input wire logic bulk_in_send,
    input wire logic bulk_in_nak,
    input wire logic bulk_in_fifo_clr,
    input wire logic bulk_out_fifo_clr,
    input wire logic ep1_toggle_clr,
    input wire logic ep2_toggle_clr
);
    // ==========================================
    // request shapes
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    sequence s_set_cfg;
        setup_valid && setup_rtype == 8'h00 && setup_req == `USBSR_REQ_SET_CONFIG;
    endsequence
    sequence s_get_cfg;
        setup_valid && setup_rtype == 8'h80 && setup_req == `USBSR_REQ_GET_CONFIG;
    endsequence
    sequence s_get_ep;
        setup_valid && setup_rtype == 8'h82 && setup_req == `USBSR_REQ_GET_STATUS
            && setup_index[3:0] inside {4'h1, 4'h2};
    endsequence
    // ==========================================
    // properties
    chk_cfg_answer: assert property (s_get_cfg |=> ans_valid)
        else $error("config read not answered");
    chk_ep_answer: assert property (s_get_ep |=> ans_valid)
        else $error("endpoint status read not answered");
    chk_no_stray_ans: assert property (ans_valid |-> $past(setup_valid))
        else $error("answer without request");
    chk_in_answer: assert property (in_token |=> bulk_in_send != bulk_in_nak)
        else $error("in token not answered once");
    chk_in_cause: assert property ((bulk_in_send || bulk_in_nak) |-> $past(in_token))
        else $error("in answer without token");
    chk_ep1_flush: assert property (ep1_error |=> bulk_in_fifo_clr)
        else $error("bulk-in fifo not emptied on stall");
    chk_ep2_flush: assert property (ep2_error |=> bulk_out_fifo_clr)
        else $error("bulk-out fifo not emptied on stall");
    chk_cfg_toggle: assert property (s_set_cfg |=> ep1_toggle_clr && ep2_toggle_clr)
        else $error("toggles not reset on set config");
    chk_addr_apply: assert property (!$stable(dev_addr) |-> $past(status_ok))
        else $error("address applied without status stage");
    chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
        && $stable(s_axi_bresp))
        else $error("write response dropped early");
endmodule
`default_nettype wire

// file: tb/usbsr_top_tb.sv
// testbench of the standard request state block
`timescale 1ns/1ps
`default_nettype none
`include "usbsr_consts.vh"
module usbsr_top_tb;
    // ==========================================
    // stimulus and dut
    logic ref_clk = 1'h0;
    logic rstn = 1'h0;
    logic [17:0] awaddr = 18'h0;
    logic [17:0] araddr = 18'h0;
    logic [31:0] wdata = 32'h0;
    logic awv = 1'h0, wv = 1'h0, bready = 1'h0, arv = 1'h0, rready = 1'h0;
    logic ep1_busy = 1'h0, ep2_busy = 1'h0, ep1_error = 1'h0, ep2_error = 1'h0;
    logic in_token = 1'h0;
    wire awrdy, wrdy, bvalid, arrdy, rvalid, ans_valid, in_send, in_nak, irq, sv, sok, out_acc;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [7:0] ans_data, srt, srq;
    wire [15:0] sval, sidx;
    wire [6:0] dev_addr;
    logic [1:0] rsp;
    logic [31:0] rdat;
    int fails = 0;
    int total_checks = 0;
    // order: addr cnf ep1 ep2 ctrl mode irq mask
    logic [15:0] rg [8] = '{`USBSR_IDX_ADDR, `USBSR_IDX_CNF, `USBSR_IDX_EP1, `USBSR_IDX_EP2,
        `USBSR_IDX_CTRL, `USBSR_IDX_MODE, `USBSR_IDX_IRQ, `USBSR_IDX_MASK};
    always #50 ref_clk = ~ref_clk;
    usbsr_host_model u_host (.ref_clk(ref_clk), .setup_valid(sv), .setup_rtype(srt),
        .setup_req(srq), .setup_value(sval), .setup_index(sidx), .status_ok(sok));
    usbsr_top u_dut (.ref_clk(ref_clk), .rstn(rstn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awv), .s_axi_awready(awrdy), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
        .s_axi_arready(arrdy), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .setup_valid(sv), .setup_rtype(srt),
        .setup_req(srq), .setup_value(sval), .setup_index(sidx), .status_ok(sok),
        .ep1_busy(ep1_busy), .ep2_busy(ep2_busy), .ep1_error(ep1_error),
        .ep2_error(ep2_error), .in_token(in_token), .ans_valid(ans_valid),
        .ans_data(ans_data), .dev_addr(dev_addr), .bulk_in_send(in_send),
        .bulk_in_nak(in_nak), .bulk_out_accept(out_acc), .bulk_in_fifo_clr(),
        .bulk_out_fifo_clr(), .ep1_toggle_clr(), .ep2_toggle_clr(), .irq(irq));
    // ==========================================
    // shared tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        @(posedge ref_clk);
        awaddr <= {idx, 2'h0};
        wdata <= {24'h0, d};
        awv <= 1'h1;
        wv <= 1'h1;
        bready <= 1'h1;
        do begin
            @(posedge ref_clk);
            if (awv && awrdy) awv <= 1'h0;
            if (wv && wrdy) wv <= 1'h0;
        end while (bvalid !== 1'h1);
        rsp = bresp;
        bready <= 1'h0;
    endtask
    task automatic rd(input logic [15:0] idx);
        @(posedge ref_clk);
        araddr <= {idx, 2'h0};
        arv <= 1'h1;
        rready <= 1'h1;
        do begin
            @(posedge ref_clk);
            if (arv && arrdy) arv <= 1'h0;
        end while (rvalid !== 1'h1);
        rdat = rdata;
        rsp = rresp;
        rready <= 1'h0;
    endtask
    task automatic tok(input logic [1:0] exp);
        @(posedge ref_clk);
        in_token <= 1'h1;
        @(posedge ref_clk);
        in_token <= 1'h0;
        @(negedge ref_clk);
        chk({in_send, in_nak}, exp);
    endtask
    task automatic ask(input logic [7:0] rt, input logic [7:0] rq, input logic [15:0] ix,
        input logic [7:0] exp);
        u_host.req(rt, rq, 16'h0000, ix);
        @(negedge ref_clk);
        chk(ans_valid, 1'h1);
        chk(ans_data, exp);
    endtask
    // ==========================================
    // scenarios
    task automatic t_reset;
        for (int i = 0; i < 4; i++) begin
            rd(rg[i]);
            chk(rdat, 32'h0);
        end
        rd(16'h0100);
        chk(rsp, `USBSR_RESP_SLVERR);
        wr(16'h0100, 8'h01);
        chk(rsp, `USBSR_RESP_SLVERR);
    endtask
    task automatic t_gate;
        wr(rg[4], 8'h00);
        for (int e = 0; e < 2; e++) begin
            wr(rg[2+e], 8'h01);
            rd(rg[2+e]);
            chk(rdat, 32'h0);
        end
        wr(rg[4], 8'h01);
        for (int e = 0; e < 2; e++) begin
            ep1_busy <= (e == 0);
            ep2_busy <= (e == 1);
            wr(rg[2+e], 8'h01);
            ep1_busy <= 1'h0;
            ep2_busy <= 1'h0;
            rd(rg[2+e]);
            chk(rdat, 32'h0);
            wr(rg[2+e], 8'hFF);
            rd(rg[2+e]);
            chk(rdat, 32'h1);
            ask(8'h82, `USBSR_REQ_GET_STATUS, 16'h0001 + e, 8'h01);
            wr(rg[2+e], 8'h00);
            rd(rg[2+e]);
            chk(rdat, 32'h0);
        end
    endtask
    task automatic t_stall;
        wr(rg[4], 8'h07);
        wr(rg[7], 8'h00);
        wr(rg[6], 8'h0F);
        tok(2'h2);
        @(posedge ref_clk);
        ep1_error <= 1'h1;
        @(posedge ref_clk);
        ep1_error <= 1'h0;
        rd(rg[4]);
        chk(rdat, 32'h5);
        rd(rg[2]);
        chk(rdat, 32'h1);
        tok(2'h1);
        chk(out_acc, 1'h1);
        @(posedge ref_clk);
        ep2_error <= 1'h1;
        @(posedge ref_clk);
        ep2_error <= 1'h0;
        rd(rg[4]);
        chk(rdat, 32'h1);
        chk(out_acc, 1'h0);
        rd(rg[3]);
        chk(rdat, 32'h1);
        // masked events stay silent
        rd(rg[6]);
        chk(rdat, 32'h3);
        chk(irq, 1'h0);
        wr(rg[7], 8'h03);
        rd(rg[6]);
        chk(irq, 1'h1);
        wr(rg[6], 8'h03);
        rd(rg[6]);
        chk(rdat, 32'h0);
        chk(irq, 1'h0);
    endtask
    task automatic t_feature;
        u_host.req(8'h02, `USBSR_REQ_CLR_FEATURE, 16'h0000, 16'h0001);
        rd(rg[2]);
        chk(rdat, 32'h0);
        u_host.req(8'h02, `USBSR_REQ_SET_FEATURE, 16'h0000, 16'h0001);
        rd(rg[2]);
        chk(rdat, 32'h1);
        u_host.req(8'h01, `USBSR_REQ_SET_INTF, 16'h0000, 16'h0000);
        rd(rg[2]);
        chk(rdat, 32'h0);
        rd(rg[3]);
        chk(rdat, 32'h0);
        u_host.req(8'h02, `USBSR_REQ_SET_FEATURE, 16'h0000, 16'h0002);
        u_host.req(8'h02, `USBSR_REQ_CLR_FEATURE, 16'h0000, 16'h0002);
        rd(rg[3]);
        chk(rdat, 32'h0);
        u_host.req(8'h02, `USBSR_REQ_SET_FEATURE, 16'h0000, 16'h0002);
    endtask
    task automatic t_addr;
        u_host.req(8'h00, `USBSR_REQ_SET_ADDRESS, 16'h0055, 16'h0000);
        rd(rg[0]);
        chk(rdat, 32'h55);
        chk(dev_addr, 7'h00);
        u_host.ok(3);
        @(negedge ref_clk);
        chk(dev_addr, 7'h55);
    endtask
    task automatic t_cfg;
        u_host.req(8'h00, `USBSR_REQ_SET_CONFIG, 16'h0003, 16'h0000);
        rd(rg[1]);
        chk(rdat, 32'h3);
        rd(rg[5]);
        chk(rdat, 32'h1);
        rd(rg[3]);
        chk(rdat, 32'h0);
        rd(rg[6]);
        chk(rdat, 32'hF);
        ask(8'h80, `USBSR_REQ_GET_CONFIG, 16'h0000, 8'h03);
        u_host.req(8'h00, `USBSR_REQ_SET_CONFIG, 16'h0000, 16'h0000);
        rd(rg[5]);
        chk(rdat, 32'h0);
    endtask
    // ==========================================
    // run control
    task automatic wrap_up;
        if (fails == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge ref_clk);
        rstn <= 1'h1;
        repeat (3) @(posedge ref_clk);
        t_reset;
        t_gate;
        t_stall;
        t_feature;
        t_addr;
        t_cfg;
        wrap_up;
    end
    // about two hundred cycles expected, so this only trips on a hang
    initial begin
        repeat (20000) @(posedge ref_clk);
        fails++;
        wrap_up;
    end
endmodule
bind usbsr_top usbsr_sva u_sva (.ref_clk(ref_clk), .rstn(rstn), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .setup_valid(setup_valid),
    .setup_rtype(setup_rtype), .setup_req(setup_req), .setup_index(setup_index),
    .status_ok(status_ok), .ep1_error(ep1_error), .ep2_error(ep2_error),
    .in_token(in_token), .ans_valid(ans_valid), .dev_addr(dev_addr),
    .bulk_in_send(bulk_in_send), .bulk_in_nak(bulk_in_nak),
    .bulk_in_fifo_clr(bulk_in_fifo_clr), .bulk_out_fifo_clr(bulk_out_fifo_clr),
    .ep1_toggle_clr(ep1_toggle_clr), .ep2_toggle_clr(ep2_toggle_clr));
`default_nettype wire
